// *** core/secp_core.sv ***
// serial eeprom command decoder, write latch, status register and write protection
`timescale 1ns/1ps
module secp_core
  import secp_pkg::*;
#(
  parameter int ARR_ADDR_W = 15,
  parameter int unsigned WC_COUNT = WC_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_si,
  input wire logic i_hold_n,
  input wire logic i_wp_n,
  input wire logic [7:0] i_arr_rdata,
  output logic o_so,
  output logic o_so_oe_n,
  output logic o_busy,
  output logic o_arr_we,
  output logic [ARR_ADDR_W-1:0] o_arr_addr,
  output logic [7:0] o_arr_wdata
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic op_is(input logic [7:0] byte_in, input logic [7:0] op);
    op_is = ((byte_in & OP_MASK) == op);
  endfunction

  // address falls inside a read-only segment for the given guard level
  function automatic logic guarded(input logic [15:0] a, input logic [1:0] g);
    logic [1:0] top;
    // top two bits of the configured width pick the quarter
    top = a[ARR_ADDR_W-1 -: 2];
    case (g)
      2'h1: guarded = (top == 2'h3);
      2'h2: guarded = top[1];
      2'h3: guarded = 1'b1;
      default: guarded = 1'b0;
    endcase
  endfunction

  // status byte as the host reads it
  function automatic logic [7:0] status_of(input logic bsy, input logic wl, input logic [1:0] g,
    input logic pe);
    logic [7:0] s;
    s = '0;
    if (bsy) begin
      s = ST_BUSY_VALUE;
    end else begin
      s[ST_WEL] = wl;
      s[ST_GUARD_LO] = g[0];
      s[ST_GUARD_HI] = g[1];
      s[ST_PPE] = pe;
    end
    status_of = s;
  endfunction

  // states that take or give serial bits
  function automatic logic shifts_in(input secp_state_t s);
    shifts_in = (s == SECP_OPC) || (s == SECP_ADR_HI) || (s == SECP_ADR_LO) || (s == SECP_WDAT);
  endfunction

  function automatic logic shifts_out(input secp_state_t s);
    shifts_out = (s == SECP_STAT) || (s == SECP_RDAT);
  endfunction

  // end point held at the counter's own width
  localparam logic [23:0] WC_LAST = 24'(WC_COUNT - 1);

  secp_regs_t q;
  secp_regs_t next_q;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic sck_rise;
    logic sck_fall;
    logic cs_fall;
    logic cs_rise;
    logic hw_prot;
    logic [7:0] byte_in;
    logic [7:0] status;
    logic [7:0] src;
    logic frame_ok;
    logic sr_ok;
    logic arr_ok;
    sck_rise = 1'b0;
    sck_fall = 1'b0;
    cs_fall = 1'b0;
    cs_rise = 1'b0;
    hw_prot = 1'b0;
    byte_in = '0;
    status = '0;
    src = '0;
    frame_ok = 1'b0;
    sr_ok = 1'b0;
    arr_ok = 1'b0;
    next_q = q;

    // pins pass two flops; only the second stage feeds logic
    // third flop only finds edges, so stage one is never read by logic
    next_q.cs_s1 = i_cs_n;
    next_q.cs_s2 = q.cs_s1;
    next_q.cs_d = q.cs_s2;
    next_q.sck_s1 = i_sck;
    next_q.sck_s2 = q.sck_s1;
    next_q.sck_d = q.sck_s2;
    next_q.si_s1 = i_si;
    next_q.si_s2 = q.si_s1;
    next_q.hold_s1 = i_hold_n;
    next_q.hold_s2 = q.hold_s1;
    next_q.wp_s1 = i_wp_n;
    next_q.wp_s2 = q.wp_s1;
    next_q.wp_d = q.wp_s2;
    next_q.arr_we = 1'b0;

    // ----------------------------------------------------------------
    // edge detection
    // ----------------------------------------------------------------
    sck_rise = q.sck_s2 & ~q.sck_d;
    sck_fall = ~q.sck_s2 & q.sck_d;
    cs_fall = ~q.cs_s2 & q.cs_d;
    cs_rise = q.cs_s2 & ~q.cs_d;
    // pin is blocked while the enable bit is 0
    hw_prot = q.ppe & ~q.wp_s2;
    byte_in = {q.in_sr, q.si_s2};

    // ----------------------------------------------------------------
    // commit checks at the end of a write frame
    // ----------------------------------------------------------------
    // a partial byte or a cleared latch leaves everything untouched
    frame_ok = cs_rise && !q.busy && q.have_data && (q.bitcnt == 3'h0) && q.wel;
    sr_ok = frame_ok && op_is(q.opcode, OP_WR_STAT) && !hw_prot && !q.sr_abort;
    arr_ok = frame_ok && op_is(q.opcode, OP_WR_ARR) && !guarded(q.addr, q.guard);

    // ----------------------------------------------------------------
    // status byte
    // ----------------------------------------------------------------
    status = status_of(q.busy, q.wel, q.guard, q.ppe);

    // ----------------------------------------------------------------
    // internal write cycle
    // ----------------------------------------------------------------
    if (q.busy) begin
      if (q.wc_cnt == WC_LAST) begin
        next_q.busy = 1'b0;
        next_q.wc_cnt = '0;
        next_q.wel = 1'b0;
        if (q.sr_pend) begin
          next_q.ppe = q.new_sr[2];
          next_q.guard = q.new_sr[1:0];
          next_q.sr_pend = 1'b0;
        end
      end else begin
        next_q.wc_cnt = q.wc_cnt + 24'h00_0001;
      end
    end

    // ----------------------------------------------------------------
    // hold: level taken only while the serial clock is low
    // ----------------------------------------------------------------
    if (q.cs_s2) begin
      next_q.paused = 1'b0;
    end else if (!q.sck_s2) begin
      next_q.paused = ~q.hold_s2;
    end

    // ----------------------------------------------------------------
    // write protect pin
    // ----------------------------------------------------------------
    // a protect pin fall during a status write frame kills the write while the enable bit is set
    if (!q.cs_s2 && q.wp_d && !q.wp_s2 && q.ppe && op_is(q.opcode, OP_WR_STAT)) begin
      next_q.sr_abort = 1'b1;
    end

    // ----------------------------------------------------------------
    // framing
    // ----------------------------------------------------------------
    if (q.cs_s2) begin
      next_q.st = SECP_IDLE;
      next_q.out_live = 1'b0;
      if (sr_ok) begin
        next_q.busy = 1'b1;
        next_q.wc_cnt = '0;
        next_q.sr_pend = 1'b1;
        next_q.new_sr = {q.wdata[ST_PPE], q.wdata[ST_GUARD_HI], q.wdata[ST_GUARD_LO]};
      end else if (arr_ok) begin
        next_q.busy = 1'b1;
        next_q.wc_cnt = '0;
        next_q.arr_we = 1'b1;
        next_q.arr_addr = q.addr;
        next_q.arr_wdata = q.wdata;
      end
    end else if (cs_fall) begin
      // a new frame forgets any dead state
      next_q.st = SECP_OPC;
      next_q.bitcnt = '0;
      next_q.have_data = 1'b0;
      next_q.sr_abort = 1'b0;
      next_q.outcnt = '0;
      next_q.out_live = 1'b0;
      next_q.opcode = '0;
    end else if (!q.paused && sck_rise) begin
      // ----------------------------------------------------------------
      // serial input
      // ----------------------------------------------------------------
      if (shifts_in(q.st)) begin
        next_q.in_sr = byte_in[6:0];
        next_q.bitcnt = q.bitcnt + 3'h1;
        if (q.bitcnt == 3'h7) begin
          case (q.st)
            SECP_OPC: begin
              next_q.opcode = byte_in;
              // busy lets only status reads through
              if (q.busy && !op_is(byte_in, OP_RD_STAT)) begin
                next_q.st = SECP_DEAD;
              end else if (op_is(byte_in, OP_SET_WEL)) begin
                next_q.wel = 1'b1;
                next_q.st = SECP_DEAD;
              end else if (op_is(byte_in, OP_CLR_WEL)) begin
                next_q.wel = 1'b0;
                next_q.st = SECP_DEAD;
              end else if (op_is(byte_in, OP_RD_STAT)) begin
                next_q.st = SECP_STAT;
              end else if (op_is(byte_in, OP_WR_STAT)) begin
                next_q.st = q.wel ? SECP_WDAT : SECP_DEAD;
              end else if (op_is(byte_in, OP_RD_ARR)) begin
                next_q.st = SECP_ADR_HI;
              end else if (op_is(byte_in, OP_WR_ARR)) begin
                next_q.st = q.wel ? SECP_ADR_HI : SECP_DEAD;
              end else begin
                next_q.st = SECP_DEAD;
              end
            end
            SECP_ADR_HI: begin
              next_q.addr[15:8] = byte_in;
              next_q.st = SECP_ADR_LO;
            end
            SECP_ADR_LO: begin
              next_q.addr[7:0] = byte_in;
              if (op_is(q.opcode, OP_RD_ARR)) begin
                next_q.st = SECP_RDAT;
                // loaded early so data is ready by the first fall
                next_q.arr_addr = {q.addr[15:8], byte_in};
              end else begin
                next_q.st = SECP_WDAT;
              end
            end
            default: begin
              // only the first data byte of a frame is kept
              if (!q.have_data) begin
                next_q.wdata = byte_in;
              end
              next_q.have_data = 1'b1;
            end
          endcase
        end
      end
    end else if (!q.paused && sck_fall && shifts_out(q.st)) begin
      // ----------------------------------------------------------------
      // serial output
      // ----------------------------------------------------------------
      // first fall after the last input bit puts out the msb
      src = (q.st == SECP_STAT) ? status : i_arr_rdata;
      next_q.out_live = 1'b1;
      next_q.outcnt = q.outcnt + 3'h1;
      if (q.outcnt == 3'h0) begin
        next_q.so = src[7];
        next_q.out_sr = {src[6:0], 1'b0};
      end else begin
        next_q.so = q.out_sr[7];
        next_q.out_sr = {q.out_sr[6:0], 1'b0};
      end
      if (q.outcnt == 3'h7 && q.st == SECP_RDAT) begin
        // address rolls over at the top of the array
        next_q.arr_addr = q.arr_addr + 16'h0001;
      end
    end

    // ----------------------------------------------------------------
    // output enable
    // ----------------------------------------------------------------
    // released one clock after select high or a pause is seen
    next_q.so_oe_n = ~(next_q.out_live & ~next_q.paused & ~q.cs_s2 &
                       shifts_out(next_q.st));
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // ce low freezes the synchronisers too, so edges are seen late after it
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q <= SECP_RST;
    end else if (i_ce) begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_so = q.so;
  assign o_so_oe_n = q.so_oe_n;
  assign o_busy = q.busy;
  assign o_arr_we = q.arr_we;
  assign o_arr_addr = q.arr_addr[ARR_ADDR_W-1:0];
  assign o_arr_wdata = q.arr_wdata;

endmodule

// *** core/secp_pkg.sv ***
// shared constants and types of the serial eeprom command and protect front end
package secp_pkg;

  // ----------------------------------------------------------------
  // opcodes (bit 3 is a don't care, cleared by the mask)
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_MASK = 8'hF7;
  localparam logic [7:0] OP_SET_WEL = 8'h06;
  localparam logic [7:0] OP_CLR_WEL = 8'h04;
  localparam logic [7:0] OP_RD_STAT = 8'h05;
  localparam logic [7:0] OP_WR_STAT = 8'h01;
  localparam logic [7:0] OP_RD_ARR = 8'h03;
  localparam logic [7:0] OP_WR_ARR = 8'h02;

  // ----------------------------------------------------------------
  // status register layout and reset values
  // ----------------------------------------------------------------
  localparam int ST_BUSY = 0;
  localparam int ST_WEL = 1;
  localparam int ST_GUARD_LO = 2;
  localparam int ST_GUARD_HI = 3;
  localparam int ST_PPE = 7;
  localparam logic [7:0] ST_BUSY_VALUE = 8'hFF;
  localparam logic [1:0] RST_GUARD = 2'h0;
  localparam logic RST_PPE = 1'b0;
  localparam logic RST_WEL = 1'b0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int WC_TIME_NS = 5_000_000;
  localparam int WC_CYCLES = WC_TIME_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SECP_IDLE = 3'h0,
    SECP_OPC = 3'h1,
    SECP_ADR_HI = 3'h3,
    SECP_ADR_LO = 3'h2,
    SECP_WDAT = 3'h6,
    SECP_RDAT = 3'h7,
    SECP_STAT = 3'h5,
    SECP_DEAD = 3'h4
  } secp_state_t;

  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic cs_d;
    logic sck_s1;
    logic sck_s2;
    logic sck_d;
    logic si_s1;
    logic si_s2;
    logic hold_s1;
    logic hold_s2;
    logic wp_s1;
    logic wp_s2;
    logic wp_d;
    logic paused;
    secp_state_t st;
    logic [2:0] bitcnt;
    logic [6:0] in_sr;
    logic [7:0] opcode;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic have_data;
    logic sr_abort;
    logic [7:0] out_sr;
    logic [2:0] outcnt;
    logic out_live;
    logic so;
    logic so_oe_n;
    logic wel;
    logic ppe;
    logic [1:0] guard;
    logic busy;
    logic [23:0] wc_cnt;
    logic sr_pend;
    logic [2:0] new_sr;
    logic arr_we;
    logic [15:0] arr_addr;
    logic [7:0] arr_wdata;
  } secp_regs_t;

  localparam secp_regs_t SECP_RST = '{cs_s1: 1'b1, cs_s2: 1'b1, cs_d: 1'b1,
    hold_s1: 1'b1, hold_s2: 1'b1, wp_s1: 1'b1, wp_s2: 1'b1, wp_d: 1'b1,
    so_oe_n: 1'b1, st: SECP_IDLE, wel: RST_WEL, ppe: RST_PPE, guard: RST_GUARD,
    default: '0};

endpackage

// *** tb/secp_core_props.sv ***
// port assertions of the serial eeprom command and protect front end
`timescale 1ns/1ps
module secp_core_props
  import secp_pkg::*;
#(
  parameter int ARR_ADDR_W = 15,
  parameter int unsigned WC_COUNT = WC_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_si,
  input wire logic i_hold_n,
  input wire logic i_wp_n,
  input wire logic [7:0] i_arr_rdata,
  input wire logic o_so,
  input wire logic o_so_oe_n,
  input wire logic o_busy,
  input wire logic o_arr_we,
  input wire logic [ARR_ADDR_W-1:0] o_arr_addr,
  input wire logic [7:0] o_arr_wdata
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // busy run length, cleared whenever busy drops
  logic [31:0] busy_len;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      busy_len <= '0;
    end else begin
      busy_len <= o_busy ? busy_len + 32'd1 : '0;
    end
  end
  // pin sync delay is three clocks, so six gives margin
  sequence s_desel; i_cs_n [*6]; endsequence
  sequence s_paused; (!i_hold_n) [*6]; endsequence
  property p_desel_hiz; s_desel |-> o_so_oe_n; endproperty
  property p_pause_hiz; s_paused |-> o_so_oe_n; endproperty
  property p_so_on_fall; $changed(o_so) && !o_so_oe_n |-> !$past(i_sck, 3) && $past(i_sck, 4);
  endproperty
  property p_we_pulse; o_arr_we |=> !o_arr_we; endproperty
  property p_we_desel; o_arr_we |-> i_cs_n && $past(i_cs_n, 3); endproperty
  property p_busy_start; $rose(o_busy) |-> i_cs_n && $past(i_cs_n, 2); endproperty
  property p_busy_len; $fell(o_busy) |-> busy_len == WC_COUNT; endproperty
  property p_busy_quiet; o_busy && $past(o_busy) |-> !o_arr_we; endproperty
  property p_we_busy; o_arr_we |-> ##[0:1] o_busy; endproperty
  a_desel_hiz: assert property (p_desel_hiz) else $error("output on while deselected");
  a_pause_hiz: assert property (p_pause_hiz) else $error("output on while paused");
  a_so_on_fall: assert property (p_so_on_fall) else $error("output moved off fall");
  a_we_pulse: assert property (p_we_pulse) else $error("write strobe too long");
  a_we_desel: assert property (p_we_desel) else $error("write while selected");
  a_busy_start: assert property (p_busy_start) else $error("busy while selected");
  a_busy_len: assert property (p_busy_len) else $error("write cycle length");
  a_busy_quiet: assert property (p_busy_quiet) else $error("write during busy");
  a_we_busy: assert property (p_we_busy) else $error("write without busy");
endmodule
bind secp_core secp_core_props #(.ARR_ADDR_W(ARR_ADDR_W), .WC_COUNT(WC_COUNT)) u_props (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(i_ce), .i_cs_n(i_cs_n), .i_sck(i_sck),
  .i_si(i_si), .i_hold_n(i_hold_n), .i_wp_n(i_wp_n), .i_arr_rdata(i_arr_rdata),
  .o_so(o_so), .o_so_oe_n(o_so_oe_n), .o_busy(o_busy), .o_arr_we(o_arr_we),
  .o_arr_addr(o_arr_addr), .o_arr_wdata(o_arr_wdata));

// *** tb/secp_host.sv ***
// serial host model driving select, clock, data and pause pins
`timescale 1ns/1ps
module secp_host (
  input wire logic i_clk,
  input wire logic i_so,
  input wire logic i_so_oe_n,
  output logic o_cs_n,
  output logic o_sck,
  output logic o_si,
  output logic o_hold_n
);
  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_si = 1'b0;
    o_hold_n = 1'b1;
  end
  // half of a 400 ns link clock period
  task automatic half();
    repeat (4) @(negedge i_clk);
  endtask
  task automatic sel();
    o_cs_n = 1'b0;
    half();
  endtask
  task automatic desel();
    half();
    o_cs_n = 1'b1;
    o_si = ~o_si;
    repeat (3) half();
  endtask
  // pause at bit 4 toggles clock and data, both must be ignored
  task automatic xfer(input logic [7:0] tx, input bit pz, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      o_si = tx[i];
      if (pz && i == 4) begin
        o_hold_n = 1'b0;
        repeat (2) begin
          half();
          o_sck = 1'b1;
          o_si = ~o_si;
          half();
          o_sck = 1'b0;
        end
        o_si = tx[i];
        o_hold_n = 1'b1;
      end
      half();
      o_sck = 1'b1;
      half();
      rx[i] = i_so_oe_n ? 1'bz : i_so;
      o_sck = 1'b0;
    end
  endtask
endmodule

// *** tb/secp_core_test.sv ***
// self-checking bench of the serial eeprom command and protect front end
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module secp_core_test;
  import secp_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic wp_n = 1'b1;
  logic [7:0] rdata = 8'h00;
  logic cs_n, sck, si, hold_n, so, so_oe_n, busy, we;
  logic [14:0] addr;
  logic [7:0] wdata, r;
  logic [7:0] mem [0:32767];
  logic [7:0] bad [3] = '{8'h07, 8'h10, 8'h00};
  int err_total = 0;
  int compares = 0;
  int writes = 0;
  always #25 clk = ~clk;
  // array stand-in, updated on the write strobe
  always @(negedge clk) begin
    rdata <= mem[addr];
    if (we === 1'b1) begin
      mem[addr] <= wdata;
      writes++;
    end
  end
  secp_host host (.i_clk(clk), .i_so(so), .i_so_oe_n(so_oe_n), .o_cs_n(cs_n), .o_sck(sck),
    .o_si(si), .o_hold_n(hold_n));
  // long enough that a status frame fits inside a cycle
  secp_core #(.ARR_ADDR_W(15), .WC_COUNT(400)) dut (.i_clk(clk), .i_arst_n(arst_n),
    .i_ce(1'b1), .i_cs_n(cs_n), .i_sck(sck), .i_si(si), .i_hold_n(hold_n), .i_wp_n(wp_n),
    .i_arr_rdata(rdata), .o_so(so), .o_so_oe_n(so_oe_n), .o_busy(busy), .o_arr_we(we),
    .o_arr_addr(addr), .o_arr_wdata(wdata));
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic frame(input logic [7:0] b [$], input bit pz);
    host.sel();
    foreach (b[i]) host.xfer(b[i], pz && i == 1, r);
    host.desel();
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 1000) begin
      @(negedge clk);
      k++;
    end
    if (k == 1000) begin
      err_total++;
      test_done();
    end
  endtask
  task automatic stat(input string n, input logic [7:0] e, input bit pz);
    frame({8'h05, 8'h00}, pz);
    `CHK(n, e, r)
  endtask
  task automatic prog(input logic [7:0] b [$]);
    frame({8'h06}, 1'b0);
    frame(b, 1'b0);
    wait_idle();
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    mem[15'h1235] = 8'h3C;
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    stat("status after reset", 8'h00, 1'b0);
    foreach (bad[i]) begin
      frame({bad[i], 8'h05, 8'h00}, 1'b0);
      `CHK("bad opcode output", 8'hzz, r)
    end
    $display("test reset and bad opcodes done");
    frame({8'h0E}, 1'b0);
    stat("latch set", 8'h02, 1'b0);
    frame({8'h0C}, 1'b0);
    stat("latch cleared", 8'h00, 1'b0);
    frame({8'h02, 8'h12, 8'h34, 8'h5A}, 1'b0);
    `CHK("write without latch", 0, writes)
    $display("test latch done");
    frame({8'h06}, 1'b0);
    frame({8'h0A, 8'h12, 8'h34, 8'hA5}, 1'b0);
    stat("busy status", 8'hFF, 1'b0);
    wait_idle();
    stat("latch after cycle", 8'h00, 1'b0);
    `CHK("stored byte", 8'hA5, mem[15'h1234])
    frame({8'h0B, 8'h12, 8'h34, 8'h00, 8'h00}, 1'b0);
    `CHK("read next byte", 8'h3C, r)
    $display("test array write done");
    prog({8'h01, 8'h84});
    stat("guard and enable", 8'h84, 1'b1);
    prog({8'h02, 8'h70, 8'h00, 8'h11});
    `CHK("guarded write", 1, writes)
    prog({8'h02, 8'h5F, 8'hFF, 8'h22});
    `CHK("open write", 8'h22, mem[15'h5FFF])
    $display("test guard done");
    wp_n = 1'b0;
    prog({8'h01, 8'h00});
    stat("hw protected", 8'h86, 1'b0);
    prog({8'h02, 8'h01, 8'h00, 8'h33});
    `CHK("write under pin", 8'h33, mem[15'h0100])
    wp_n = 1'b1;
    prog({8'h01, 8'h00});
    stat("unprotected", 8'h00, 1'b0);
    $display("test pin protect done");
    test_done();
  end
endmodule
